/* spi_register_access_outputs.sv */
`timescale 1ns/100ps
`default_nettype none
`include "spi_out_defs.svh"

module spi_register_access_outputs
(
  input  wire logic                  sys_clk,        // System clock
  input  wire logic                  nrst,           // Async reset, low
  input  wire logic                  cs_n,           // Chip select pin
  input  wire logic                  sclk,           // Serial clock pin
  input  wire logic                  din,            // Serial data in pin
  output logic                       dout,           // Serial data out
  output logic                       dout_oe_n,      // Low while driving
  input  wire logic                  sample_strobe,  // One pulse per sample
  input  wire spi_out_pkg::value_t   x_sample,       // X, signed
  input  wire spi_out_pkg::value_t   y_sample,       // Y, signed
  input  wire logic [11:0]           supply_sample,  // Supply, binary
  input  wire logic [11:0]           aux_sample,     // Aux converter
  input  wire logic [11:0]           temp_sample,    // Temperature
  input  wire logic [15:0]           event_one_word, // Event record one
  input  wire logic [15:0]           event_two_word, // Event record two
  input  wire logic                  fault_alarm,    // Fault or alarm level
  output logic                       wr_pulse,       // Byte write strobe
  output logic [5:0]                 wr_addr,        // Byte address
  output logic [7:0]                 wr_byte         // Byte data
);
  import spi_out_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte address to register slot; both bytes map alike
  function automatic slot_t slot_of(input logic [5:0] a);
    unique case ({a[5:1], 1'b0})
      `ADDR_SUPPLY:    slot_of = 4'h0;
      `ADDR_X_ACCEL:   slot_of = 4'h1;
      `ADDR_Y_ACCEL:   slot_of = 4'h2;
      `ADDR_AUX:       slot_of = 4'h3;
      `ADDR_TEMP:      slot_of = 4'h4;
      `ADDR_X_PEAK:    slot_of = 4'h5;
      `ADDR_Y_PEAK:    slot_of = 4'h6;
      `ADDR_XY_MAG:    slot_of = 4'h7;
      `ADDR_XY_PEAK:   slot_of = 4'h8;
      `ADDR_EVENT_ONE: slot_of = 4'h9;
      `ADDR_EVENT_TWO: slot_of = 4'hA;
      default:         slot_of = 4'hF;
    endcase
  endfunction

  // Magnitude of a signed sample; -8192 still fits unsigned
  function automatic value_t mag14(input value_t v);
    mag14 = v[13] ? value_t'(~v + 14'h0001) : v;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [1:0] cs_sync;
  logic [1:0] sclk_sync;
  logic [1:0] din_sync;
  logic       cs_q;
  logic       sclk_q;

  // Two flops per pin; only stage two feeds logic
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cs_sync   <= 2'h3;
      sclk_sync <= 2'h3;
      din_sync  <= 2'h0;
      cs_q      <= 1'b1;
      sclk_q    <= 1'b1;
    end
    else
    begin
      cs_sync   <= {cs_sync[0], cs_n};
      sclk_sync <= {sclk_sync[0], sclk};
      din_sync  <= {din_sync[0], din};
      cs_q      <= cs_sync[1];
      sclk_q    <= sclk_sync[1];
    end
  end

  logic active;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;

  // Clock edges count only inside a frame
  assign active    = !cs_sync[1] && !cs_q;
  assign cs_fall   = cs_q && !cs_sync[1];
  assign cs_rise   = !cs_q && cs_sync[1];
  assign sclk_rise = active && sclk_sync[1] && !sclk_q;
  assign sclk_fall = active && !sclk_sync[1] && sclk_q;

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  logic [15:0] rx_shift;
  logic [4:0]  bit_cnt;

  // Counter saturates so a long frame is also refused
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_shift <= 16'h0000;
      bit_cnt  <= 5'd0;
    end
    else if (cs_fall)
      bit_cnt <= 5'd0;
    else if (sclk_rise)
    begin
      rx_shift <= {rx_shift[14:0], din_sync[1]};
      if (bit_cnt != 5'h1F)
        bit_cnt <= bit_cnt + 5'd1;
    end
  end

  logic frame_ok;
  logic is_write;
  logic is_read;

  // Only a full 16-clock frame is decoded
  assign frame_ok = cs_rise && (bit_cnt == `FRAME_BITS);
  assign is_write = frame_ok && rx_shift[`WRITE_BIT]
                    && !rx_shift[`RW_SECOND_BIT];
  assign is_read  = frame_ok && !rx_shift[`WRITE_BIT]
                    && !rx_shift[`RW_SECOND_BIT];

  // ----------------------------------------------------------------
  // Byte writes and peak clear command
  // ----------------------------------------------------------------
  logic peak_clear;

  // One byte per write frame, passed out for the control registers
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_pulse   <= 1'b0;
      wr_addr    <= 6'h00;
      wr_byte    <= 8'h00;
      peak_clear <= 1'b0;
    end
    else
    begin
      wr_pulse   <= is_write;
      peak_clear <= is_write && rx_shift[13:8] == `ADDR_COMMAND_LO
                    && rx_shift[`CMD_PEAK_CLEAR];
      if (is_write)
      begin
        wr_addr <= rx_shift[13:8];
        wr_byte <= rx_shift[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Root sum square of X and Y
  // ----------------------------------------------------------------
  sqrt_state_e sq_state;
  logic [27:0] sq_sum;
  value_t      sq_root;
  logic [3:0]  sq_bit;
  logic        mag_done;
  value_t      x_mag;
  value_t      y_mag;
  value_t      sq_trial;

  assign x_mag    = mag14(x_sample);
  assign y_mag    = mag14(y_sample);
  assign sq_trial = sq_root | value_t'(14'h0001 << sq_bit);

  // Bit-serial square root, one result bit per clock, 14 clocks
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sq_state <= SQ_IDLE;
      sq_sum   <= 28'h0000000;
      sq_root  <= 14'h0000;
      sq_bit   <= 4'd0;
      mag_done <= 1'b0;
    end
    else
    begin
      mag_done <= 1'b0;
      unique case (sq_state)
        SQ_IDLE:
          if (sample_strobe)
          begin
            // Operands widened first so the squares keep all 28 bits
            sq_sum   <= 28'(x_mag) * 28'(x_mag) + 28'(y_mag) * 28'(y_mag);
            sq_root  <= 14'h0000;
            sq_bit   <= 4'(`MAG_BITS - 1);
            sq_state <= SQ_RUN;
          end
        SQ_RUN:
        begin
          if (28'(sq_trial) * 28'(sq_trial) <= sq_sum)
            sq_root <= sq_trial;
          if (sq_bit == 4'd0)
          begin
            mag_done <= 1'b1;
            sq_state <= SQ_IDLE;
          end
          else
            sq_bit <= sq_bit - 4'd1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output data registers
  // ----------------------------------------------------------------
  logic [11:0] supply_r;
  logic [11:0] aux_r;
  logic [11:0] temp_r;
  value_t      x_r;
  value_t      y_r;
  value_t      x_pk;
  value_t      y_pk;
  value_t      mag_r;
  value_t      mag_pk;
  logic [15:0] ev1_r;
  logic [15:0] ev2_r;

  // Refresh every sample whether or not anyone reads
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      supply_r <= 12'h000;
      aux_r    <= 12'h000;
      temp_r   <= 12'h000;
      x_r      <= 14'h0000;
      y_r      <= 14'h0000;
      mag_r    <= 14'h0000;
      ev1_r    <= 16'h0000;
      ev2_r    <= 16'h0000;
    end
    else
    begin
      if (sample_strobe)
      begin
        supply_r <= supply_sample;
        aux_r    <= aux_sample;
        temp_r   <= temp_sample;
        x_r      <= x_sample;
        y_r      <= y_sample;
        ev1_r    <= event_one_word;
        ev2_r    <= event_two_word;
      end
      if (mag_done)
        mag_r <= sq_root;
    end
  end

  // Peaks keep sign for X and Y; a clear beats a new peak
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      x_pk   <= 14'h0000;
      y_pk   <= 14'h0000;
      mag_pk <= 14'h0000;
    end
    else if (peak_clear)
    begin
      x_pk   <= 14'h0000;
      y_pk   <= 14'h0000;
      mag_pk <= 14'h0000;
    end
    else
    begin
      if (sample_strobe && x_mag > mag14(x_pk))
        x_pk <= x_sample;
      if (sample_strobe && y_mag > mag14(y_pk))
        y_pk <= y_sample;
      if (mag_done && sq_root > mag_pk)
        mag_pk <= sq_root;
    end
  end

  // ----------------------------------------------------------------
  // Fresh-data flags and read mux
  // ----------------------------------------------------------------
  logic [10:0] fresh;
  logic [10:0] fresh_set;
  logic [10:0] fresh_clr;
  slot_t       rd_slot;
  logic        rd_pending;
  value_t      rd_value;

  // Peaks are refreshed along with their sources
  assign fresh_set = {{2{sample_strobe}}, {2{mag_done}},
                      {7{sample_strobe}}};
  assign fresh_clr = (cs_fall && rd_pending && rd_slot != 4'hF)
                     ? 11'(11'h001 << rd_slot) : 11'h000;

  // A refresh in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      fresh <= 11'h000;
    else
      fresh <= (fresh & ~fresh_clr) | fresh_set;
  end

  // Twelve-bit results leave bits 13:12 at zero
  always_comb
  begin
    unique case (rd_slot)
      4'h0:    rd_value = {2'b00, supply_r};
      4'h1:    rd_value = x_r;
      4'h2:    rd_value = y_r;
      4'h3:    rd_value = {2'b00, aux_r};
      4'h4:    rd_value = {2'b00, temp_r};
      4'h5:    rd_value = x_pk;
      4'h6:    rd_value = y_pk;
      4'h7:    rd_value = mag_r;
      4'h8:    rd_value = mag_pk;
      4'h9:    rd_value = ev1_r[13:0];
      4'hA:    rd_value = ev2_r[13:0];
      default: rd_value = 14'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Read pipeline and transmit path
  // ----------------------------------------------------------------
  logic [15:0] tx_shift;

  // Request from one frame is served in the next
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_slot    <= 4'hF;
      rd_pending <= 1'b0;
    end
    else if (is_read)
    begin
      rd_slot    <= slot_of(rx_shift[13:8]);
      rd_pending <= 1'b1;
    end
    else if (frame_ok)
      rd_pending <= 1'b0;
  end

  // Load at frame start; shift only after the first rising clock
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      tx_shift <= 16'h0000;
    else if (cs_fall)
    begin
      if (rd_pending && rd_slot != 4'hF)
        tx_shift <= {fresh[rd_slot], fault_alarm, rd_value};
      else
        tx_shift <= 16'h0000;
    end
    else if (sclk_fall && bit_cnt != 5'd0)
      tx_shift <= {tx_shift[14:0], 1'b0};
  end

  // Pin released whenever chip select is high
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dout      <= 1'b0;
      dout_oe_n <= 1'b1;
    end
    else
    begin
      dout      <= tx_shift[15];
      dout_oe_n <= !active;
    end
  end

endmodule
`default_nettype wire

/* spi_out_defs.svh */
`ifndef SPI_OUT_DEFS_SVH
`define SPI_OUT_DEFS_SVH
// Lower-byte addresses of the output data registers
`define ADDR_SUPPLY     6'h02
`define ADDR_X_ACCEL    6'h04
`define ADDR_Y_ACCEL    6'h06
`define ADDR_AUX        6'h08
`define ADDR_TEMP       6'h0A
`define ADDR_X_PEAK     6'h0C
`define ADDR_Y_PEAK     6'h0E
`define ADDR_XY_MAG     6'h18
`define ADDR_XY_PEAK    6'h1A
`define ADDR_EVENT_ONE  6'h1C
`define ADDR_EVENT_TWO  6'h1E
// Command register, lower byte, and its peak clear bit
`define ADDR_COMMAND_LO 6'h3E
`define CMD_PEAK_CLEAR  5
// Output word fields
`define FRESH_BIT       15
`define ALARM_BIT       14
// Frame framing and magnitude width
`define FRAME_BITS      5'd16
`define WRITE_BIT       15
`define RW_SECOND_BIT   14
`define MAG_BITS        14
`endif

/* spi_out_pkg.sv */
package spi_out_pkg;
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b01,
    SQ_RUN  = 2'b10
  } sqrt_state_e;
  typedef logic [3:0]  slot_t;
  typedef logic [13:0] value_t;
endpackage

/* spi_register_access_outputs_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module spi_register_access_outputs_monitor
(
  input wire logic       sys_clk,   // Clock
  input wire logic       nrst,      // Reset, low
  input wire logic       cs_n,      // Select pin
  input wire logic       sclk,      // Serial clock
  input wire logic       dout,      // Serial out
  input wire logic       dout_oe_n, // Out enable
  input wire logic       wr_pulse,  // Write strobe
  input wire logic [5:0] wr_addr,   // Byte address
  input wire logic [7:0] wr_byte    // Byte data
);
  // ----------------------------------------
  // Link checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_desel; cs_n [*5]; endsequence
  sequence s_sel; !cs_n [*5]; endsequence
  sequence s_clk_hi; (sclk && !cs_n) [*3]; endsequence
  property p_oe_idle; s_desel |-> dout_oe_n; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("dout driven while idle");
  property p_oe_drive; s_sel |-> !dout_oe_n; endproperty
  a_oe_drive: assert property (p_oe_drive) else $error("dout not driven");
  property p_oe_start; $fell(dout_oe_n) |-> !cs_n; endproperty
  a_oe_start: assert property (p_oe_start) else $error("drive began unselected");
  property p_oe_stop; $rose(dout_oe_n) |-> cs_n; endproperty
  a_oe_stop: assert property (p_oe_stop) else $error("release while selected");
  // Bits move only after a falling serial clock, never while it is high
  property p_dout_hold; s_clk_hi |-> $stable(dout); endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("dout moved on high clock");
  property p_wr_one; wr_pulse |=> !wr_pulse; endproperty
  a_wr_one: assert property (p_wr_one) else $error("write strobe too long");
  property p_wr_cs; wr_pulse |-> cs_n && $past(cs_n, 2); endproperty
  a_wr_cs: assert property (p_wr_cs) else $error("write before frame end");
  property p_wr_hold; !wr_pulse |-> $stable(wr_addr) && $stable(wr_byte); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write fields moved");
  // Reset state is checked even while reset is held
  property p_rst; disable iff (1'b0) !nrst ##1 !nrst |-> dout_oe_n && !wr_pulse; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
endmodule
bind spi_register_access_outputs spi_register_access_outputs_monitor mon_u (.sys_clk(sys_clk),
  .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .dout(dout), .dout_oe_n(dout_oe_n),
  .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_byte(wr_byte));
`default_nettype wire

/* spi_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module spi_host_model
(
  input  wire logic sys_clk,   // Timing base
  output logic      cs_n,      // Select
  output logic      sclk,      // Serial clock, idles low
  output logic      din,       // Data to device
  input  wire logic dout,      // Data from device
  input  wire logic dout_oe_n  // Device enable
);
  // ----------------------------------------
  // Frame engine
  // ----------------------------------------
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end
  // Eight system clocks per serial clock gives the 400 ns period
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge sys_clk) cs_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    for (int i = 0; i < nbits; i++)
    begin
      din = tx[15-i];
      repeat (4) @(negedge sys_clk);
      sclk = 1'b1;
      // A released line reads as the inverse so a late enable shows up
      rx = {rx[14:0], dout_oe_n ? ~dout : dout};
      repeat (4) @(negedge sys_clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    cs_n = 1'b1;
    // Released line must not look like the last bit
    din = ~din;
    repeat (10) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

/* spi_register_access_outputs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module spi_register_access_outputs_tb;
  import spi_out_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, strobe = 1'b0, fault = 1'b1;
  logic cs_n, sclk, din, dout, dout_oe_n, wr_pulse;
  logic [5:0] wr_addr;
  logic [7:0] wr_byte;
  value_t x = 14'h0078, y = 14'h3FCE;
  logic [15:0] rx;
  int checks = 0, n_mismatch = 0, n_wr = 0;
  logic [5:0] ra [13] = '{6'h02, 6'h05, 6'h06, 6'h09, 6'h0A, 6'h0C, 6'h0F,
                          6'h18, 6'h1B, 6'h1C, 6'h1F, 6'h04, 6'h20};
  logic [15:0] ev [13] = '{16'hCABC, 16'hC078, 16'hFFCE, 16'hC123, 16'hC4FE,
    16'hC078, 16'hFFCE, 16'hC082, 16'hC082, 16'hFFFF, 16'hC155, 16'h4078, 16'h0000};
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (wr_pulse === 1'b1) n_wr <= n_wr + 1;
  spi_register_access_outputs dut_u (.sys_clk(sys_clk), .nrst(nrst), .cs_n(cs_n),
    .sclk(sclk), .din(din), .dout(dout), .dout_oe_n(dout_oe_n), .sample_strobe(strobe),
    .x_sample(x), .y_sample(y), .supply_sample(12'hABC), .aux_sample(12'h123),
    .temp_sample(12'h4FE), .event_one_word(16'hFFFF), .event_two_word(16'h0155),
    .fault_alarm(fault), .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_byte(wr_byte));
  spi_host_model host_u (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout(dout), .dout_oe_n(dout_oe_n));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One strobe, then time for the root calculation to finish
  task automatic sample;
    @(negedge sys_clk) strobe = 1'b1;
    @(negedge sys_clk) strobe = 1'b0;
    repeat (20) @(negedge sys_clk);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    n_mismatch++;
    give_verdict;
  end
  initial
  begin
    repeat (20) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (10) @(negedge sys_clk);
    sample;
    // Pipelined reads over every register; 12-bit ones mask bits 13:12
    for (int i = 0; i <= 13; i++)
    begin
      host_u.xfer({2'b00, (i < 13) ? ra[i] : 6'h00, 8'h5A}, 16, rx);
      if (i > 0 && ra[i-1][5:1] inside {5'd1, 5'd4, 5'd5})
        chk(rx & 16'hCFFF, ev[i-1]);
      else if (i > 0)
        chk(rx, ev[i-1]);
    end
    $display("test read_all done");
    fault = 1'b0;
    x = 14'h000A;
    y = 14'h0005;
    sample;
    host_u.xfer(16'hBF20, 16, rx);
    chk({2'b00, wr_addr, wr_byte}, 16'h3F20);
    host_u.xfer(16'h0C00, 16, rx);
    host_u.xfer(16'h0400, 16, rx);
    chk(rx & 16'h7FFF, 16'h0078);
    host_u.xfer(16'h0000, 16, rx);
    chk(rx, 16'h800A);
    $display("test refresh done");
    host_u.xfer(16'hBE20, 16, rx);
    host_u.xfer(16'h0C00, 16, rx);
    host_u.xfer(16'h1A00, 16, rx);
    chk(rx & 16'h7FFF, 16'h0000);
    host_u.xfer(16'h0000, 16, rx);
    chk(rx & 16'h7FFF, 16'h0000);
    chk(n_wr[15:0], 16'h0002);
    $display("test peak_clear done");
    host_u.xfer(16'hB155, 8, rx);
    host_u.xfer(16'hB1AA, 15, rx);
    host_u.xfer(16'hFE20, 16, rx);
    chk(n_wr[15:0], 16'h0002);
    chk({2'b00, wr_addr, wr_byte}, 16'h3E20);
    $display("test short_frame done");
    give_verdict;
  end
endmodule
`default_nettype wire
